// ===== verilog/rx_alarm_defs.svh
/*
  Register offsets, field positions and reset values for the receive alarm
  interrupt block. Assumes inclusion by bare name from design files.
*/
`ifndef RX_ALARM_DEFS_SVH
`define RX_ALARM_DEFS_SVH

`define ADDR_W 8
`define DATA_W 8
`define EV_W 7
`define OFF_CFG_STATUS 8'h11
`define OFF_ENABLE_FIRST 8'h12
`define OFF_ENABLE_SECOND 8'h13
`define OFF_STATUS_FIRST 8'h14
`define OFF_STATUS_SECOND 8'h15
`define OFF_MODE 8'h16
`define REG_RESET 8'h00
`define EV_RESET 7'h00
`define ENABLE2_MASK 7'h5F
`define ENABLE2_LAPD_MASK 7'h7F
`define MESSAGE_BITS_MASK 7'h60
`define BIT_SYNC_MSG 6
`define BIT_SEQ_LOSS 5
`define BIT_ALIGN_CHANGE 4
`define BIT_OUT_FRAME 3
`define BIT_LOST_FRAME 2
`define BIT_TRACE_MSG 6
`define BIT_FAR_BLOCK 4
`define BIT_FAR_FAIL 3
`define BIT_MONITOR_ERR 2
`define BIT_OCTET_ERR 1
`define BIT_PAYLOAD_MIS 0
`define BIT_LAPD_ENABLE 5
`define BIT_LOS_STATE 6
`define BIT_AIS_STATE 7
`define BIT_LOS_EVENT 1
`define BIT_AIS_EVENT 0
`define BIT_MODE_1995 0
`define BIT_MODE_LAPD 1
`define BIT_MODE_SUPPRESS 2
`define LOS_ZERO_RUN 6'd32
`define LOS_SPAN_LEN 6'd32
`define LOS_SHORT_RUN 3'd4

`endif

// ===== verilog/rx_alarm_pkg.sv
/*
  Types shared by the receive alarm interrupt block.
  Assumes rx_alarm_defs.svh supplies the widths.
*/
`include "rx_alarm_defs.svh"
package rx_alarm_pkg;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`DATA_W-1:0] data_t;
  typedef logic [`EV_W-1:0] ev_t;
  typedef enum logic [1:0] {LOS_CLEAR, LOS_DECLARED} los_state_t;
endpackage : rx_alarm_pkg

// ===== verilog/rx_event_latch.sv
/*
  Bank of reset-upon-read event flags.
  Assumes events and the read strobe are on the same clock.
*/
`timescale 1ns/10ps
`include "rx_alarm_defs.svh"
module rx_event_latch (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire rx_alarm_pkg::ev_t event_in,
  input wire logic read_clear_in,
  output rx_alarm_pkg::ev_t flags_out
);
  import rx_alarm_pkg::*;

  typedef struct packed {
    ev_t flags;
  } latch_state_t;

  latch_state_t state;
  latch_state_t next_state;

  always_comb begin
    next_state = state;
    // Set wins over the read clear so no event is lost
    next_state.flags = (read_clear_in ? `EV_RESET : state.flags) | event_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state <= '{flags: `EV_RESET};
    end else if (clk_en_in) begin
      state <= next_state;
    end
  end

  assign flags_out = state.flags;
endmodule : rx_event_latch

// ===== verilog/rx_los_detect.sv
/*
  Loss-of-signal detector on the recovered line bit stream.
  Assumes bit_valid_in marks one received bit, already synchronised.
*/
`timescale 1ns/10ps
`include "rx_alarm_defs.svh"
module rx_los_detect (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic bit_valid_in,
  input wire logic bit_in,
  output logic los_out,
  output logic change_out
);
  import rx_alarm_pkg::*;

  typedef struct packed {
    los_state_t mode;
    logic [5:0] zero_run;
    logic [5:0] span_cnt;
    logic [2:0] short_run;
    logic span_bad;
    logic change;
  } los_t;

  los_t state;
  los_t next_state;

  function automatic logic [5:0] sat_inc(input logic [5:0] v);
    sat_inc = (v == 6'h3F) ? v : v + 6'h01;
  endfunction : sat_inc

  always_comb begin
    next_state = state;
    next_state.change = 1'b0;
    if (bit_valid_in) begin
      case (state.mode)
        LOS_CLEAR: begin
          next_state.zero_run = bit_in ? 6'h00 : sat_inc(state.zero_run);
          if (!bit_in && sat_inc(state.zero_run) >= `LOS_ZERO_RUN) begin
            next_state.mode = LOS_DECLARED;
            next_state.change = 1'b1;
            next_state.span_cnt = 6'h00;
            next_state.short_run = 3'h0;
            next_state.span_bad = 1'b0;
          end
        end
        LOS_DECLARED: begin
          // Window of 32 bits must hold no run of four zeros
          next_state.short_run = bit_in ? 3'h0 :
            ((state.short_run == `LOS_SHORT_RUN) ? state.short_run : state.short_run + 3'h1);
          next_state.span_bad = state.span_bad |
            (!bit_in && state.short_run + 3'h1 >= `LOS_SHORT_RUN);
          next_state.span_cnt = sat_inc(state.span_cnt);
          if (sat_inc(state.span_cnt) >= `LOS_SPAN_LEN) begin
            // Judge the finished span before its verdict flag is cleared
            if (!next_state.span_bad) begin
              next_state.mode = LOS_CLEAR;
              next_state.change = 1'b1;
              next_state.zero_run = 6'h00;
            end
            next_state.span_cnt = 6'h00;
            next_state.span_bad = 1'b0;
          end
        end
        default: begin
          next_state.mode = LOS_CLEAR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state <= '{mode: LOS_CLEAR, zero_run: 6'h00, span_cnt: 6'h00, short_run: 3'h0,
                 span_bad: 1'b0, change: 1'b0};
    end else if (clk_en_in) begin
      state <= next_state;
    end
  end

  assign los_out = (state.mode == LOS_DECLARED);
  assign change_out = state.change;
endmodule : rx_los_detect

// ===== verilog/rx_alarm_irq.sv
/*
  Receive alarm interrupt block for one E3 G.832 channel: enable and
  reset-upon-read status registers, live alarm states and one interrupt request.
  Assumes framer event pulses and alarm levels come from logic on ref_clk_in;
  the line bit stream comes from outside and is synchronised here.
*/
`timescale 1ns/10ps
`include "rx_alarm_defs.svh"
module rx_alarm_irq (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire rx_alarm_pkg::addr_t addr_in,
  input wire rx_alarm_pkg::data_t wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output rx_alarm_pkg::data_t rd_data_out,
  input wire logic sync_status_message_change_in,
  input wire logic status_message_sequence_loss_change_in,
  input wire logic frame_alignment_change_in,
  input wire logic out_of_frame_declare_in,
  input wire logic in_frame_from_acquisition_in,
  input wire logic loss_of_frame_enter_in,
  input wire logic in_frame_from_octet_check_in,
  input wire logic alarm_indication_signal_in,
  input wire logic trail_trace_message_buffer_change_in,
  input wire logic link_message_received_in,
  input wire logic far_end_block_error_in,
  input wire logic far_end_receive_failure_change_in,
  input wire logic error_monitor_byte_error_in,
  input wire logic framing_octet_error_in,
  input wire logic payload_type_mismatch_in,
  input wire logic line_bit_valid_in,
  input wire logic line_bit_in,
  output logic irq_out
);
  import rx_alarm_pkg::*;

  typedef struct packed {
    ev_t enable_first;
    ev_t enable_second;
    logic [2:0] mode;
    logic [1:0] line_meta;
    logic [1:0] line_sync;
    logic ais_prev;
    data_t rd_data;
    logic irq;
  } top_t;

  top_t state;
  top_t next_state;
  ev_t status_first;
  ev_t status_second;
  ev_t events_first;
  ev_t events_second;
  logic los_now;
  logic los_change;
  logic rd_first;
  logic rd_second;

  function automatic logic hit(input addr_t a, input addr_t off);
    hit = (a == off);
  endfunction : hit

  function automatic data_t widen(input ev_t v);
    widen = {1'b0, v};
  endfunction : widen

  assign rd_first = clk_en_in && rd_en_in && hit(addr_in, `OFF_STATUS_FIRST);
  assign rd_second = clk_en_in && rd_en_in && hit(addr_in, `OFF_STATUS_SECOND);

  // Line pins cross from the line side, so two flops before the detector
  rx_los_detect los_detect (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .bit_valid_in(state.line_sync[1]),
    .bit_in(state.line_sync[0]),
    .los_out(los_now),
    .change_out(los_change)
  );

  always_comb begin
    events_first = `EV_RESET;
    events_first[`BIT_SYNC_MSG] = sync_status_message_change_in;
    events_first[`BIT_SEQ_LOSS] = status_message_sequence_loss_change_in;
    events_first[`BIT_ALIGN_CHANGE] = frame_alignment_change_in;
    events_first[`BIT_OUT_FRAME] = out_of_frame_declare_in | in_frame_from_acquisition_in;
    events_first[`BIT_LOST_FRAME] = loss_of_frame_enter_in | in_frame_from_octet_check_in;
    events_first[`BIT_LOS_EVENT] = los_change;
    events_first[`BIT_AIS_EVENT] = alarm_indication_signal_in ^ state.ais_prev;
    // Optional suppression of the message bits in the older framing format
    if (state.mode[`BIT_MODE_1995] && state.mode[`BIT_MODE_SUPPRESS]) begin
      events_first = events_first & ~`MESSAGE_BITS_MASK;
    end
  end

  always_comb begin
    events_second = `EV_RESET;
    events_second[`BIT_TRACE_MSG] = trail_trace_message_buffer_change_in;
    events_second[`BIT_LAPD_ENABLE] = state.mode[`BIT_MODE_LAPD] && link_message_received_in;
    events_second[`BIT_FAR_BLOCK] = far_end_block_error_in;
    events_second[`BIT_FAR_FAIL] = far_end_receive_failure_change_in;
    events_second[`BIT_MONITOR_ERR] = error_monitor_byte_error_in;
    events_second[`BIT_OCTET_ERR] = framing_octet_error_in;
    events_second[`BIT_PAYLOAD_MIS] = payload_type_mismatch_in;
  end

  rx_event_latch latch_first (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .event_in(events_first),
    .read_clear_in(rd_first),
    .flags_out(status_first)
  );

  rx_event_latch latch_second (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .event_in(events_second),
    .read_clear_in(rd_second),
    .flags_out(status_second)
  );

  always_comb begin
    next_state = state;
    next_state.line_meta = {line_bit_valid_in, line_bit_in};
    next_state.line_sync = state.line_meta;
    next_state.ais_prev = alarm_indication_signal_in;
    if (wr_en_in) begin
      case (addr_in)
        `OFF_ENABLE_FIRST: next_state.enable_first = wr_data_in[`EV_W-1:0];
        `OFF_ENABLE_SECOND: begin
          // Bit 5 only writable once the link message path is switched on
          next_state.enable_second = wr_data_in[`EV_W-1:0] &
            (state.mode[`BIT_MODE_LAPD] ? `ENABLE2_LAPD_MASK : `ENABLE2_MASK);
        end
        `OFF_MODE: next_state.mode = wr_data_in[2:0];
        default: next_state.mode = state.mode;
      endcase
    end
    next_state.rd_data = `REG_RESET;
    if (rd_en_in) begin
      case (addr_in)
        `OFF_CFG_STATUS: begin
          next_state.rd_data[`BIT_LOS_STATE] = los_now;
          next_state.rd_data[`BIT_AIS_STATE] = alarm_indication_signal_in;
        end
        `OFF_ENABLE_FIRST: next_state.rd_data = widen(state.enable_first);
        `OFF_ENABLE_SECOND: next_state.rd_data = widen(state.enable_second);
        `OFF_STATUS_FIRST: next_state.rd_data = widen(status_first);
        `OFF_STATUS_SECOND: next_state.rd_data = widen(status_second);
        `OFF_MODE: next_state.rd_data = {5'h00, state.mode};
        default: next_state.rd_data = `REG_RESET;
      endcase
    end
    next_state.irq = |(status_first & state.enable_first) |
                     |(status_second & state.enable_second);
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state <= '{enable_first: `EV_RESET, enable_second: `EV_RESET, mode: 3'h0,
                 line_meta: 2'h0, line_sync: 2'h0, ais_prev: 1'b0,
                 rd_data: `REG_RESET, irq: 1'b0};
    end else if (clk_en_in) begin
      state <= next_state;
    end
  end

  assign rd_data_out = state.rd_data;
  assign irq_out = state.irq;
endmodule : rx_alarm_irq

// ===== sim/rx_alarm_irq_chk.sv
/*
  Port-level assertions for the receive alarm interrupt block.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module rx_alarm_irq_chk (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire rx_alarm_pkg::addr_t addr_in,
  input wire rx_alarm_pkg::data_t wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire rx_alarm_pkg::data_t rd_data_out,
  input wire logic alarm_indication_signal_in,
  input wire logic far_end_block_error_in,
  input wire logic payload_type_mismatch_in,
  input wire logic irq_out
);
  import rx_alarm_pkg::*;
  logic far_end_block_error_en;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Shadow enable, so the irq check needs no view inside the block
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      far_end_block_error_en <= 1'b0;
    end else if (clk_en_in && wr_en_in && addr_in == 8'h13) begin
      far_end_block_error_en <= wr_data_in[4];
    end
  end
  a_unmapped_zero: assert property (
    clk_en_in && rd_en_in && (addr_in < 8'h11 || addr_in > 8'h16) |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_bit7_zero: assert property (
    clk_en_in && rd_en_in && addr_in != 8'h11 |=> !rd_data_out[7])
    else $error("unused bit 7 reads one");
  a_en2_readback: assert property (
    (clk_en_in && wr_en_in && addr_in == 8'h13) ##1 !wr_en_in ##1
    (clk_en_in && rd_en_in && addr_in == 8'h13)
    |=> (rd_data_out & 8'h5F) == ($past(wr_data_in, 3) & 8'h5F))
    else $error("enable two readback wrong");
  a_en1_readback: assert property (
    (clk_en_in && wr_en_in && addr_in == 8'h12) ##1 !wr_en_in ##1
    (clk_en_in && rd_en_in && addr_in == 8'h12)
    |=> rd_data_out == ($past(wr_data_in, 3) & 8'h7F))
    else $error("enable one readback wrong");
  a_status_read_clear: assert property (
    (clk_en_in && rd_en_in && addr_in == 8'h15) ##1 (rd_en_in && addr_in == 8'h15)
    |=> rd_data_out[0] == $past(payload_type_mismatch_in, 2))
    else $error("status two clear or keep wrong");
  a_far_end_block_error_irq: assert property (
    clk_en_in && far_end_block_error_in && far_end_block_error_en && !(wr_en_in && addr_in == 8'h13)
    |-> ##[1:2] irq_out)
    else $error("enabled event gave no irq");
  a_irq_fall_cause: assert property (
    $fell(irq_out) |-> $past(rd_en_in, 2) || $past(wr_en_in, 2))
    else $error("irq fell without read or write");
  a_reset_quiet: assert property (
    $fell(rst_in) |-> !irq_out && rd_data_out == 8'h00)
    else $error("outputs not clear after reset");
  a_ais_state: assert property (
    alarm_indication_signal_in [*3] ##0 (clk_en_in && rd_en_in && addr_in == 8'h11)
    |=> rd_data_out[7])
    else $error("alarm state not shown");
  cover property (irq_out);
  cover property ($fell(irq_out));
  cover property (rd_en_in && addr_in == 8'h15 ##1 rd_en_in && addr_in == 8'h15);
endmodule : rx_alarm_irq_chk

bind rx_alarm_irq rx_alarm_irq_chk u_chk (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
  .rd_data_out(rd_data_out), .alarm_indication_signal_in(alarm_indication_signal_in),
  .far_end_block_error_in(far_end_block_error_in),
  .payload_type_mismatch_in(payload_type_mismatch_in), .irq_out(irq_out)
);

// ===== sim/rx_alarm_irq_bench.sv
/*
  Self-checking bench for the receive alarm interrupt block.
  Assumes the checker binds itself; clock enable drops once to test the freeze.
*/
`timescale 1ns/10ps
module rx_alarm_irq_bench;
  import rx_alarm_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr_en, rd_en, alarm_indication_signal, lv, lb, irq, ce;
  addr_t addr;
  data_t wd, rdat;
  logic [14:0] pv;
  int bad_count, num_checks, cyc;
  int pb[13] = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 10, 11, 12, 14};
  data_t ex[13] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h08, 8'h04, 8'h04,
    8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40};
  rx_alarm_irq u_dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(ce), .addr_in(addr),
    .wr_data_in(wd), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdat),
    .sync_status_message_change_in(pv[0]), .status_message_sequence_loss_change_in(pv[1]),
    .frame_alignment_change_in(pv[2]), .out_of_frame_declare_in(pv[3]),
    .in_frame_from_acquisition_in(pv[4]), .loss_of_frame_enter_in(pv[5]),
    .in_frame_from_octet_check_in(pv[6]), .alarm_indication_signal_in(alarm_indication_signal),
    .payload_type_mismatch_in(pv[8]), .framing_octet_error_in(pv[9]),
    .error_monitor_byte_error_in(pv[10]), .far_end_receive_failure_change_in(pv[11]),
    .far_end_block_error_in(pv[12]), .link_message_received_in(pv[13]),
    .trail_trace_message_buffer_change_in(pv[14]), .line_bit_valid_in(lv),
    .line_bit_in(lb), .irq_out(irq)
  );
  always #5 ref_clk_in = ~ref_clk_in;
  task give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  task chk(input data_t g, input data_t e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Strobes drop for one cycle between calls, so no signal is set twice in a step
  task wr(input addr_t a, input data_t d);
    addr <= a;
    wd <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk_in);
    wr_en <= 1'b0;
    @(posedge ref_clk_in);
  endtask : wr
  task rd(input addr_t a, input data_t e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk_in);
    rd_en <= 1'b0;
    @(posedge ref_clk_in);
    chk(rdat, e);
  endtask : rd
  task ev(input logic [14:0] v);
    pv <= v;
    @(posedge ref_clk_in);
    pv <= '0;
    @(posedge ref_clk_in);
  endtask : ev
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    {wr_en, rd_en, alarm_indication_signal, lv, lb} = '0;
    ce = 1'b1;
    addr = '0;
    wd = '0;
    pv = '0;
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    for (int a = 17; a <= 22; a++) rd(8'(a), 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'h00);
    wr(8'h13, 8'hFF);
    rd(8'h13, 8'h5F);
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'h7F);
    for (int i = 0; i < 13; i++) begin
      ev(15'(1) << pb[i]);
      @(posedge ref_clk_in);
      chk({7'h00, irq}, 8'h01);
      rd(i < 7 ? 8'h14 : 8'h15, ex[i]);
      rd(i < 7 ? 8'h14 : 8'h15, 8'h00);
      chk({7'h00, irq}, 8'h00);
    end
    wr(8'h13, 8'h00);
    ev(15'h1000);
    @(posedge ref_clk_in);
    chk({7'h00, irq}, 8'h00);
    wr(8'h13, 8'h10);
    @(posedge ref_clk_in);
    chk({7'h00, irq}, 8'h01);
    rd(8'h15, 8'h10);
    // Event lands in the first of two back-to-back reads
    addr <= 8'h15;
    rd_en <= 1'b1;
    pv <= 15'h0100;
    @(posedge ref_clk_in);
    pv <= '0;
    @(posedge ref_clk_in);
    chk(rdat, 8'h00);
    rd_en <= 1'b0;
    @(posedge ref_clk_in);
    chk(rdat, 8'h01);
    ev(15'h2000);
    rd(8'h15, 8'h00);
    wr(8'h16, 8'h02);
    wr(8'h13, 8'hFF);
    rd(8'h13, 8'h7F);
    ev(15'h2000);
    rd(8'h15, 8'h20);
    wr(8'h16, 8'h05);
    ev(15'h0003);
    rd(8'h14, 8'h00);
    wr(8'h16, 8'h00);
    alarm_indication_signal <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    rd(8'h11, 8'h80);
    rd(8'h14, 8'h01);
    alarm_indication_signal <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rd(8'h14, 8'h01);
    lv <= 1'b1;
    repeat (40) @(posedge ref_clk_in);
    rd(8'h11, 8'h40);
    rd(8'h14, 8'h02);
    // A span that is all zeros must keep the loss declared
    repeat (30) @(posedge ref_clk_in);
    rd(8'h11, 8'h40);
    rd(8'h14, 8'h00);
    lb <= 1'b1;
    repeat (70) @(posedge ref_clk_in);
    rd(8'h14, 8'h02);
    rd(8'h11, 8'h00);
    // Frozen clock enable must drop the write entirely
    ce <= 1'b0;
    wr(8'h12, 8'h00);
    ce <= 1'b1;
    rd(8'h12, 8'h7F);
    // Reset in mid-run must clear the enables written earlier
    rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    rd(8'h13, 8'h00);
    rd(8'h12, 8'h00);
    chk({7'h00, irq}, 8'h00);
    give_verdict();
  end
endmodule : rx_alarm_irq_bench
